/* common/pm1_params.svh */
// offsets, field positions and reset values for the power control register block
`ifndef PM1_PARAMS_SVH
`define PM1_PARAMS_SVH
`define CTL_OFFSET 2'h0
`define BIT_OS_SEL 0
`define BIT_BM_WAKE 1
`define BIT_GLR 2
`define BIT_STYPE_LO 10
`define BIT_STYPE_HI 12
`define BIT_SLEEP 13
`define CTL_RESET 16'h0000
`define CTL_RW_MASK 16'h1C03
`endif

/* common/pm1_pkg.sv */
// types for the power control register block
package pm1_pkg;
    typedef logic [2:0] sleep_type_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [1:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } io_req_s;
    typedef struct packed {
        logic sleep_start;
        sleep_type_t sleep_type;
    } sleep_cmd_s;
    typedef enum logic [0:0] {
        ST_AWAKE = 1'b0,
        ST_ASLEEP = 1'b1
    } power_state_e;
endpackage

/* verif/pm1_chk.sv */
// port assertions for the power control block
`timescale 1ns/1ns
`default_nettype none
module pm1_chk
    import pm1_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire io_req_s io_req,
    input wire logic pm_event,
    input wire logic cpu_in_c3,
    input wire logic [15:0] io_rdata,
    input wire logic os_control_interrupt,
    input wire logic c3_exit,
    input wire logic firmware_event_status,
    input wire sleep_cmd_s sleep_cmd,
    input wire logic asleep
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic w0 = clk_en && io_req.wr && io_req.addr == 2'h0;
    sequence s_slp; w0 && io_req.be[1] && io_req.wdata[13]; endsequence
    property p_slp; s_slp |=> sleep_cmd.sleep_start && asleep; endproperty
    a_slp: assert property (p_slp) else $error("no sleep");
    property p_one; sleep_cmd.sleep_start |-> $past(w0 && io_req.wdata[13]); endproperty
    a_one: assert property (p_one) else $error("stray pulse");
    property p_typ; s_slp |=> sleep_cmd.sleep_type == $past(io_req.wdata[12:10]); endproperty
    a_typ: assert property (p_typ) else $error("bad type");
    property p_rsv; (io_rdata & 16'hE3FC) == 16'h0000; endproperty
    a_rsv: assert property (p_rsv) else $error("bit set");
    property p_rdz; clk_en && io_req.rd && io_req.addr != 2'h0 |=> io_rdata == 16'h0000; endproperty
    a_rdz: assert property (p_rdz) else $error("not zero");
    property p_c3; c3_exit |-> $past(cpu_in_c3); endproperty
    a_c3: assert property (p_c3) else $error("bad wake");
    property p_glr; w0 && io_req.be[0] && io_req.wdata[2] |=> firmware_event_status; endproperty
    a_glr: assert property (p_glr) else $error("no event");
    property p_os; os_control_interrupt |-> $past(pm_event, 3); endproperty
    a_os: assert property (p_os) else $error("bad irq");
endmodule
bind pm1_sleep_control pm1_chk u_chk (.*);
`default_nettype wire

/* verif/pm1_host.sv */
// host model issuing control block accesses
`timescale 1ns/1ns
`default_nettype none
module pm1_host
    import pm1_pkg::*;
(
    input wire logic ref_clk,
    output var io_req_s io_req
);
    initial io_req = '0;
    task automatic acc(logic w, logic [1:0] a, b, logic [15:0] d);
        @(negedge ref_clk) io_req = {~w, w, a, b, d};
        @(negedge ref_clk) io_req = {4'h0, b, ~d};
    endtask
endmodule
`default_nettype wire

/* verif/pm1_sleep_control_tb.sv */
// bench for the power control block
`timescale 1ns/1ns
`default_nettype none
module pm1_sleep_control_tb;
    import pm1_pkg::*;
    logic ref_clk = 0, rst_n = 0, clk_en = 1, pm_event = 0, busmaster_req = 0, cpu_in_c3 = 0;
    logic wake_event = 0, firmware_event_enable = 0, firmware_status_clear = 0;
    logic wake_status_clear = 0, os_control_interrupt, firmware_mgmt_interrupt, c3_exit;
    logic firmware_event_status, wake_status, asleep;
    logic [15:0] io_rdata;
    io_req_s io_req;
    sleep_cmd_s sleep_cmd;
    int fail_count = 0, tests_run = 0;
    pm1_host u_host (
        .ref_clk(ref_clk),
        .io_req(io_req)
    );
    pm1_sleep_control u_dut (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .io_req(io_req),
        .pm_event(pm_event),
        .busmaster_req(busmaster_req),
        .cpu_in_c3(cpu_in_c3),
        .wake_event(wake_event),
        .firmware_event_enable(firmware_event_enable),
        .firmware_status_clear(firmware_status_clear),
        .wake_status_clear(wake_status_clear),
        .io_rdata(io_rdata),
        .os_control_interrupt(os_control_interrupt),
        .firmware_mgmt_interrupt(firmware_mgmt_interrupt),
        .c3_exit(c3_exit),
        .firmware_event_status(firmware_event_status),
        .wake_status(wake_status),
        .sleep_cmd(sleep_cmd),
        .asleep(asleep)
    );
    initial forever #5 ref_clk = ~ref_clk;
    task chk(string n, logic [15:0] e, s);
        tests_run++;
        if (s !== e) $display("wrong value %s expected %h seen %h", n, e, s);
        if (s !== e) fail_count++;
    endtask
    task rd(logic [1:0] a, logic [15:0] e);
        u_host.acc(1'b0, a, 2'h3, 16'h0000);
        chk("io_rdata", e, io_rdata);
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge ref_clk);
        rst_n = 1;
        rd(2'h0, 16'h0000);
        firmware_event_enable = 1;
        u_host.acc(1'b1, 2'h0, 2'h3, 16'hDFFF);
        chk("fw_status", 16'h0001, 16'(firmware_event_status));
        rd(2'h0, 16'h1C03);
        chk("fw_irq", 16'h0001, 16'(firmware_mgmt_interrupt));
        u_host.acc(1'b1, 2'h0, 2'h1, 16'hFF01);
        u_host.acc(1'b1, 2'h0, 2'h2, 16'h08FE);
        rd(2'h0, 16'h0801);
        u_host.acc(1'b1, 2'h1, 2'h3, 16'hFFFF);
        rd(2'h1, 16'h0000);
        rd(2'h0, 16'h0801);
        {pm_event, busmaster_req, cpu_in_c3} = 3'h7;
        repeat (4) @(negedge ref_clk);
        chk("irq_c3", 16'h0002, 16'({os_control_interrupt, c3_exit}));
        u_host.acc(1'b1, 2'h0, 2'h1, 16'h0003);
        @(negedge ref_clk);
        chk("c3_exit", 16'h0001, 16'(c3_exit));
        for (int t = 0; t < 8; t++)
        begin
            u_host.acc(1'b1, 2'h0, 2'h3, 16'(t * 1024 + 16'h2001));
            chk("sleep_cmd", 16'(t + 8), 16'(sleep_cmd));
        end
        wake_event = 1;
        repeat (5) @(negedge ref_clk);
        chk("wake", 16'h0002, 16'({wake_status, asleep}));
        firmware_event_enable = 0;
        repeat (2) @(negedge ref_clk);
        chk("fw_irq", 16'h0000, 16'(firmware_mgmt_interrupt));
        firmware_status_clear = 1;
        u_host.acc(1'b1, 2'h0, 2'h1, 16'h0005);
        chk("fw_status", 16'h0001, 16'(firmware_event_status));
        @(negedge ref_clk);
        firmware_status_clear = 0;
        chk("fw_status", 16'h0000, 16'(firmware_event_status));
        u_host.acc(1'b1, 2'h0, 2'h1, 16'h0000);
        @(negedge ref_clk);
        chk("irq_route", 16'h0001, 16'({os_control_interrupt, firmware_mgmt_interrupt}));
        wake_status_clear = 1;
        @(negedge ref_clk);
        wake_status_clear = 0;
        repeat (2) @(negedge ref_clk);
        chk("wake", 16'h0000, 16'({wake_status, asleep}));
        cpu_in_c3 = 0;
        u_host.acc(1'b1, 2'h0, 2'h1, 16'h0002);
        repeat (2) @(negedge ref_clk);
        chk("c3_exit", 16'h0000, 16'(c3_exit));
        cpu_in_c3 = 1;
        @(negedge ref_clk);
        chk("c3_exit", 16'h0001, 16'(c3_exit));
        clk_en = 0;
        u_host.acc(1'b1, 2'h0, 2'h3, 16'h0000);
        clk_en = 1;
        rd(2'h0, 16'h1C02);
        rst_n = 0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1;
        chk("reset_st", 16'h0000, 16'({firmware_event_status, wake_status, asleep}));
        chk("reset_irq", 16'h0000, 16'({c3_exit, firmware_mgmt_interrupt}));
        chk("reset_os", 16'h0000, 16'({os_control_interrupt, sleep_cmd}));
        rd(2'h0, 16'h0000);
        end_sim;
    end
endmodule
`default_nettype wire

/* verilog/pm1_sleep_control.sv */
// power control register block: interrupt routing, c3 wake, global release, sleep trigger
// Summary of operation
// [R01] bits keep same position in either block
// [R02] bits owned elsewhere read zero, ignore writes
// [R03] block decodes at 32-bit aligned base
// [R04] byte and word accesses accepted
// [R05] resets to zero, writable bits read back
// [R06] bit 0 routes events to os or firmware
// [R07] os software preserves routing bit on writes
// [R08] bit 1 lets bus master wake c3
// [R09] bit 2 write-only, raises firmware event
// [R10] firmware status gated by firmware enable
// [R11] os writes release after freeing global lock
// [R12] bits 10-12 hold sleep type
// [R13] software programs each block's sleep type
// [R14] bit 13 write-only, reads zero
// [R15] sleep trigger starts hardware sleep sequence
// [R16] bits 14 and 15 read zero
// [R17] software ignores unsupported feature bits
// [R18] enabled wake while asleep sets wake status
// [R19] bits 3-9 read zero, writes ignored
// [R20] writing zero to pulse bits does nothing
`timescale 1ns/1ns
`default_nettype none
`include "pm1_params.svh"
module pm1_sleep_control
    import pm1_pkg::*;
#(
    parameter logic [15:0] IMPL_MASK = 16'h3C07
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire io_req_s io_req,
    input wire logic pm_event,
    input wire logic busmaster_req,
    input wire logic cpu_in_c3,
    input wire logic wake_event,
    input wire logic firmware_event_enable,
    input wire logic firmware_status_clear,
    input wire logic wake_status_clear,
    output logic [15:0] io_rdata,
    output logic os_control_interrupt,
    output logic firmware_mgmt_interrupt,
    output logic c3_exit,
    output logic firmware_event_status,
    output logic wake_status,
    output sleep_cmd_s sleep_cmd,
    output logic asleep
);
    logic [2:0] pin_raw;
    logic [2:0] pin_sync;
    logic [15:0] ctl_r, ctl_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic sci_r, sci_nxt;
    logic smi_r, smi_nxt;
    logic c3x_r, c3x_nxt;
    logic fws_r, fws_nxt;
    logic wks_r, wks_nxt;
    logic asleep_r, asleep_nxt;
    sleep_cmd_s cmd_r, cmd_nxt;
    power_state_e st_r, st_nxt;
    logic [15:0] wmask;
    logic [15:0] wbits;
    logic wr_hit;
    logic ev_pm, ev_bm, ev_wake;

    // byte lanes to bit mask
    function automatic logic [15:0] lane_mask(input logic [1:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    // address decode shared by reads and writes
    function automatic logic addr_hit(input logic [1:0] addr);
        addr_hit = (addr == `CTL_OFFSET);
    endfunction

    // external event pins pass two flops
    assign pin_raw = {wake_event, busmaster_req, pm_event};

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_sync
            logic s1_r;
            logic s2_r;
            always_ff @(posedge ref_clk)
            begin
                if (!rst_n)
                begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                end
                else if (clk_en)
                begin
                    s1_r <= pin_raw[g];
                    s2_r <= s1_r;
                end
            end
            assign pin_sync[g] = s2_r;
        end
    endgenerate

    // register group: control storage and read data
    always_comb
    begin
        wr_hit = io_req.wr && addr_hit(io_req.addr); // [R03]
        wmask = lane_mask(io_req.be) & IMPL_MASK; // [R04] [R01] [R02]
        wbits = io_req.wdata & wmask;
        ctl_nxt = ctl_r;
        if (wr_hit)
        begin
            // storage only for writable bits; reserved stay zero
            ctl_nxt = (ctl_r & ~(wmask & `CTL_RW_MASK)) | (wbits & `CTL_RW_MASK); // [R19] [R12]
        end
        rdata_nxt = rdata_r;
        if (io_req.rd)
        begin
            // pulse bits and 14-15 never read back
            rdata_nxt = addr_hit(io_req.addr) ? (ctl_r & `CTL_RW_MASK & IMPL_MASK)
                : 16'h0000; // [R05] [R14] [R16]
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ctl_r <= `CTL_RESET; // [R05]
            rdata_r <= 16'h0000;
        end
        else if (clk_en)
        begin
            ctl_r <= ctl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // event group: interrupt routing, c3 wake and firmware status
    always_comb
    begin
        ev_pm = pin_sync[0];
        ev_bm = pin_sync[1];
        sci_nxt = ev_pm && ctl_r[`BIT_OS_SEL]; // [R06]
        c3x_nxt = ev_bm && cpu_in_c3 && ctl_r[`BIT_BM_WAKE]; // [R08]
        fws_nxt = fws_r;
        if (firmware_status_clear)
        begin
            fws_nxt = 1'b0;
        end
        // a release write in the clear cycle still sets the flag
        if (wr_hit && wbits[`BIT_GLR])
        begin
            fws_nxt = 1'b1; // [R09] [R20]
        end
        smi_nxt = (ev_pm && !ctl_r[`BIT_OS_SEL]) // [R06]
            || (fws_r && firmware_event_enable); // [R10]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sci_r <= 1'b0;
            smi_r <= 1'b0;
            c3x_r <= 1'b0;
            fws_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sci_r <= sci_nxt;
            smi_r <= smi_nxt;
            c3x_r <= c3x_nxt;
            fws_r <= fws_nxt;
        end
    end

    // sleep group: trigger pulse, sleep state and wake status
    always_comb
    begin
        ev_wake = pin_sync[2];
        cmd_nxt.sleep_start = wr_hit && wbits[`BIT_SLEEP]; // [R15] [R20]
        cmd_nxt.sleep_type = wr_hit ? ctl_nxt[`BIT_STYPE_HI:`BIT_STYPE_LO]
            : ctl_r[`BIT_STYPE_HI:`BIT_STYPE_LO]; // [R12]
        st_nxt = st_r;
        wks_nxt = wks_r;
        if (wake_status_clear)
        begin
            wks_nxt = 1'b0;
        end
        case (st_r)
            ST_AWAKE:
            begin
                if (cmd_nxt.sleep_start)
                begin
                    st_nxt = ST_ASLEEP; // [R15]
                end
            end
            ST_ASLEEP:
            begin
                if (ev_wake)
                begin
                    wks_nxt = 1'b1; // [R18]
                    st_nxt = ST_AWAKE; // [R18]
                end
            end
            default:
            begin
                st_nxt = ST_AWAKE;
            end
        endcase
        asleep_nxt = (st_nxt == ST_ASLEEP);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wks_r <= 1'b0;
            cmd_r <= '0;
            st_r <= ST_AWAKE;
            asleep_r <= 1'b0;
        end
        else if (clk_en)
        begin
            wks_r <= wks_nxt;
            cmd_r <= cmd_nxt;
            st_r <= st_nxt;
            asleep_r <= asleep_nxt;
        end
    end

    assign io_rdata = rdata_r;
    assign os_control_interrupt = sci_r;
    assign firmware_mgmt_interrupt = smi_r;
    assign c3_exit = c3x_r;
    assign firmware_event_status = fws_r;
    assign wake_status = wks_r;
    assign sleep_cmd = cmd_r;
    assign asleep = asleep_r;
endmodule
`default_nettype wire
